// File: core/gate_drive_core.sv
// gate drive input protection core: filtering, interlock, undervoltage, fault latch
// Contract
// - each channel drives separate turn-on and turn-off commands
// - ready and fault output valid 150 ms after power-up
// - fault output shows no error after power-on reset if healthy
// - undervoltage forces both drive commands off
// - switching inputs ignored during undervoltage
// - undervoltage latches fault and raises fault output
// - input high requests on, low requests off
// - filter acts on turn-on and turn-off edges
// - pulses under 625 ns are suppressed
// - pulses over 750 ns always pass
// - pulses between 625 and 750 ns may go either way
// - on, off and fault information cross the barrier both ways
// - fault output low means no error, high means error
// - latched fault ignores inputs and keeps transistors off
// - fault clears after no fault and both inputs low over 9 us
// - never both on; dead time is max of interlock and controller
`timescale 1ns/100ps
`include "gate_drive_defs.svh"
module gate_drive_core #(
  parameter int POR_CYCLES = `POR_CYC
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // controller switching inputs (asynchronous pins)
  input  wire logic upper_switch_request_i,
  input  wire logic lower_switch_request_i,
  // internal supply comparator, high while below 13,5 V (asynchronous)
  input  wire logic supply_low_i,
  // fault feedback to controller
  output logic      fault_indication_out_o,
  // secondary channel commands
  output logic      upper_turn_on_cmd_o,
  output logic      upper_turn_off_cmd_o,
  output logic      lower_turn_on_cmd_o,
  output logic      lower_turn_off_cmd_o,
  // status
  output logic      ready_o
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {supply_low_i, lower_switch_request_i, upper_switch_request_i};
      sync2_r <= sync1_r;
    end
  end
  wire uv_s = sync2_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // short-pulse filters, one per switching input
  logic [1:0] filt_w;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      glitch_filter u_filt (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .raw_i     (sync2_r[g]),
        .filt_o    (filt_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state and counters
  gate_drive_pkg::core_state_t state_r;
  gate_drive_pkg::core_state_t state_nxt;
  logic [`CNT_W-1:0] por_cnt_r;
  logic [9:0]        low_cnt_r;
  logic [7:0]        dead_cnt_r;
  logic              fault_r;
  logic [1:0]        cmd_r;
  logic [1:0]        cmd_nxt;
  // off commands and ready kept in their own flops so outputs need no gates
  logic [1:0]        off_r;
  logic              ready_r;

  wire por_done  = (por_cnt_r >= `CNT_W'(POR_CYCLES - 1));
  wire both_low  = ~filt_w[0] & ~filt_w[1];
  wire low_long  = (low_cnt_r >= 10'(`CLR_CYC));
  // set beats clear: an undervoltage in the clearing cycle keeps the latch
  wire fault_set = uv_s;
  wire fault_clr = low_long & ~uv_s;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      gate_drive_pkg::ST_POR:   if (por_done) state_nxt = uv_s ? gate_drive_pkg::ST_FAULT
                                                               : gate_drive_pkg::ST_RUN;
      gate_drive_pkg::ST_RUN:   if (fault_set) state_nxt = gate_drive_pkg::ST_FAULT;
      gate_drive_pkg::ST_FAULT: if (fault_clr) state_nxt = gate_drive_pkg::ST_RUN;
      default:                  state_nxt = gate_drive_pkg::ST_POR;
    endcase
  end

  // positive logic; interlock: a channel turns on only after the other
  // has been off for the built-in dead time, and never both
  wire dead_ok = (dead_cnt_r >= 8'(`INTERLOCK_CYC));
  wire allow   = (state_r == gate_drive_pkg::ST_RUN) & ~uv_s;
  assign cmd_nxt[0] = allow & filt_w[0] & ~filt_w[1] & ~cmd_r[1] & (cmd_r[0] | dead_ok);
  assign cmd_nxt[1] = allow & filt_w[1] & ~filt_w[0] & ~cmd_r[0] & (cmd_r[1] | dead_ok);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r    <= gate_drive_pkg::ST_POR;
      por_cnt_r  <= '0;
      low_cnt_r  <= 10'h000;
      dead_cnt_r <= 8'h00;
      fault_r    <= 1'b0;
      cmd_r      <= 2'h0;
      off_r      <= 2'h3;
      ready_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (!por_done) por_cnt_r <= por_cnt_r + `CNT_W'(1);
      if (!both_low) low_cnt_r <= 10'h000;
      else if (!low_long) low_cnt_r <= low_cnt_r + 10'h001;
      if (cmd_r != 2'h0) dead_cnt_r <= 8'h00;
      else if (!dead_ok) dead_cnt_r <= dead_cnt_r + 8'h01;
      // fault latch, meaningful only after power-on
      fault_r <= (state_nxt == gate_drive_pkg::ST_FAULT);
      cmd_r   <= cmd_nxt;
      off_r   <= ~cmd_nxt;
      ready_r <= (state_nxt != gate_drive_pkg::ST_POR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // separate on/off commands per channel; high means error
  assign upper_turn_on_cmd_o    = cmd_r[0];
  assign upper_turn_off_cmd_o   = off_r[0];
  assign lower_turn_on_cmd_o    = cmd_r[1];
  assign lower_turn_off_cmd_o   = off_r[1];
  assign fault_indication_out_o = fault_r;
  assign ready_o                = ready_r;

  a_never_both: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !(cmd_r[0] && cmd_r[1])) else $error("both channels on");
  a_uv_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    uv_s |=> cmd_r == 2'h0) else $error("drive on during undervoltage");
  a_uv_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (uv_s && state_r != gate_drive_pkg::ST_POR) |=> fault_r) else $error("fault not set");
  a_por_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == gate_drive_pkg::ST_POR) |-> cmd_r == 2'h0) else $error("drive on in reset");
  a_fault_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fault_r |=> cmd_r == 2'h0) else $error("drive on while fault");
  a_fault_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(fault_r) |-> $past(low_cnt_r) >= 10'(`CLR_CYC)) else $error("fault cleared early");
  a_por_clean: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == gate_drive_pkg::ST_POR && por_done && !uv_s) |=> !fault_r)
    else $error("fault after clean reset");
  a_req_on: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (allow && filt_w == 2'b01 && cmd_r == 2'h0 && dead_ok) |=> cmd_r[0])
    else $error("upper request not honoured");
  a_req_lower: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (allow && filt_w == 2'b10 && cmd_r == 2'h0 && dead_ok) |=> cmd_r[1])
    else $error("lower request not honoured");

  ////////////////////////////////////////////////////////////////////////////
  // further output and power-on counter checks
  // on and off complementary
  a_on_off_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    off_r == ~cmd_r) else $error("on and off commands overlap");
  a_ready_state: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ready_r == (state_r != gate_drive_pkg::ST_POR)) else $error("ready out of step");
  a_ready_late: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(ready_r) |-> $past(por_done)) else $error("ready before power-on done");
  a_fault_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fault_r && !low_long) |=> fault_r) else $error("fault dropped early");
  a_dead_upper: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(cmd_r[0]) |-> $past(dead_ok)) else $error("upper on inside dead time");
  a_dead_lower: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(cmd_r[1]) |-> $past(dead_ok)) else $error("lower on inside dead time");
  a_por_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    por_done |=> $stable(por_cnt_r)) else $error("power-on counter ran on");
endmodule : gate_drive_core

// File: core/gate_drive_defs.svh
// timing constants for the gate drive input protection core
`ifndef GATE_DRIVE_DEFS_SVH
`define GATE_DRIVE_DEFS_SVH
`define CLK_PERIOD_NS      20
`define FILT_MIN_NS        625
`define FILT_MAX_NS        750
// chosen threshold inside the band: 680 ns -> 34 cycles
`define FILT_PICK_NS       680
`define FILT_CYC           (`FILT_PICK_NS / `CLK_PERIOD_NS)
`define POR_MS             150
`define POR_CYC            ((`POR_MS * 1000000) / `CLK_PERIOD_NS)
`define CLR_US             9
`define CLR_CYC            (((`CLR_US * 1000) / `CLK_PERIOD_NS) + 1)
`define INTERLOCK_NS       1000
`define INTERLOCK_CYC      (`INTERLOCK_NS / `CLK_PERIOD_NS)
`define CNT_W              24
`endif

// File: core/gate_drive_pkg.sv
// types for the gate drive input protection core
package gate_drive_pkg;
  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAULT = 2'b10
  } core_state_t;
endpackage : gate_drive_pkg

// File: core/glitch_filter.sv
// short-pulse filter for one switching input
`timescale 1ns/100ps
`include "gate_drive_defs.svh"
module glitch_filter (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // synchronised input and filtered level
  input  wire logic raw_i,
  output logic      filt_o
);
  logic [7:0] run_r;
  logic       filt_r;
  wire        differs = (raw_i != filt_r);
  // threshold sits inside the allowed band
  wire        long_enough = (run_r >= 8'(`FILT_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_r  <= 8'h00;
      filt_r <= 1'b0;
    end else if (!differs) begin
      run_r <= 8'h00;
    end else if (long_enough) begin
      run_r  <= 8'h00;
      filt_r <= raw_i;
    end else begin
      run_r <= run_r + 8'h01;
    end
  end
  assign filt_o = filt_r;

  a_long_pass: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (raw_i != filt_r) [*8] ##1 (raw_i != filt_r) [*8] ##1 (raw_i != filt_r) [*8]
    ##1 (raw_i != filt_r) [*8] ##1 (raw_i != filt_r) [*2] |=> (filt_r == $past(raw_i)))
    else $error("filter did not pass a long pulse");
  a_short_block: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $changed(filt_r) |-> $past(run_r) == 8'(`FILT_CYC - 1))
    else $error("filter output changed too early");
endmodule : glitch_filter

// File: test/gate_drive_core_tb.sv
// bench for the gate drive input protection core
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gate_drive_core_tb;
  localparam int POR_N = 20;
  logic clk_sys_i, rst_b_i, uv, up, lo, flt, u_on, u_off, l_on, l_off, rdy, m_flt, m_rdy;
  int   n_fail = 0, num_checks = 0, seed = 40145, k, d;
  gate_drive_core #(.POR_CYCLES(POR_N)) gate_drive_core_i (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .upper_switch_request_i(up), .lower_switch_request_i(lo),
    .supply_low_i(uv), .fault_indication_out_o(flt), .upper_turn_on_cmd_o(u_on),
    .upper_turn_off_cmd_o(u_off), .lower_turn_on_cmd_o(l_on),
    .lower_turn_off_cmd_o(l_off), .ready_o(rdy));
  switch_ctrl_model switch_ctrl_model_i (.clk_sys_i(clk_sys_i), .ready_i(rdy),
    .upper_o(up), .lower_o(lo));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  // reference: on only for a lone request while running healthy
  function automatic logic exp_on(input logic a, input logic b);
    return m_rdy & ~m_flt & a & ~b;
  endfunction : exp_on
  task automatic cmp_all();
    `CHK(u_on, exp_on(up, lo));
    `CHK({u_off, l_on, l_off}, {~exp_on(up, lo), exp_on(lo, up), ~exp_on(lo, up)});
    `CHK(flt, m_flt);
  endtask : cmp_all
  // a burst on the upper request; pass says whether the command must move
  task automatic pulse_chk(input int w, input logic pass);
    logic v0;
    v0 = exp_on(up, lo);
    d = 0;
    fork
      switch_ctrl_model_i.glitch(w);
    join_none
    repeat (120) begin
      cyc(1);
      d += (u_on !== v0);
    end
    `CHK(d > 0, pass);
  endtask : pulse_chk
  initial begin
    rst_b_i = 1'b0;
    uv = 1'b0;
    m_flt = 1'b0;
    m_rdy = 1'b0;
    cyc(12);
    rst_b_i = 1'b1;
    cyc(5);
    cmp_all();
    for (k = 5; rdy !== 1'b1 && k < 200; k++) cyc(1);
    if (k == 200) begin
      n_fail++;
      end_sim();
    end
    `CHK(k >= POR_N - 1 && k <= POR_N + 3, 1'b1);
    m_rdy = 1'b1;
    cyc(5);
    cmp_all();
    pulse_chk(20, 1'b0);
    pulse_chk(40, 1'b1);
    switch_ctrl_model_i.set_lvl(1'b1, 1'b0);
    cyc(120);
    cmp_all();
    pulse_chk(20, 1'b0);
    // first pass requests both channels at once
    for (k = 0; k < 8; k++) begin
      switch_ctrl_model_i.set_lvl(1'($random(seed)) | (k == 0), 1'($random(seed)) | (k == 0));
      cyc(120);
      cmp_all();
      `CHK(u_on & l_on, 1'b0);
    end
    switch_ctrl_model_i.set_lvl(1'b1, 1'b0);
    cyc(120);
    uv = 1'b1;
    cyc(6);
    m_flt = 1'b1;
    cmp_all();
    switch_ctrl_model_i.set_lvl(1'b0, 1'b1);
    cyc(120);
    cmp_all();
    uv = 1'b0;
    cyc(120);
    cmp_all();
    switch_ctrl_model_i.set_lvl(1'b0, 1'b0);
    cyc(440);
    `CHK(flt, 1'b1);
    cyc(80);
    m_flt = 1'b0;
    cmp_all();
    `CHK(switch_ctrl_model_i.n_to, 0);
    end_sim();
  end
endmodule : gate_drive_core_tb

// File: test/switch_ctrl_model.sv
// controller model driving the two switching requests
`timescale 1ns/100ps
module switch_ctrl_model (
  // clock and driver status
  input  wire logic clk_sys_i,
  input  wire logic ready_i,
  // switching requests
  output logic      upper_o,
  output logic      lower_o
);
  int cyc_r  = 0;
  int last_r = 0;
  int n_to   = 0;
  // push-pull levels from time zero, never released
  initial begin
    upper_o = 1'b0;
    lower_o = 1'b0;
  end
  always @(posedge clk_sys_i) cyc_r <= cyc_r + 1;
  // held low until ready, levels kept at least 10 us
  task automatic set_lvl(input logic up, input logic lo);
    int n;
    n = 0;
    while ((ready_i !== 1'b1 || cyc_r - last_r < 500) && n < 2000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 2000) n_to++;
    upper_o = up;
    lower_o = lo;
    last_r  = cyc_r;
  endtask : set_lvl
  // line noise on the upper request, w cycles long
  task automatic glitch(input int w);
    upper_o = ~upper_o;
    repeat (w) @(posedge clk_sys_i);
    #1;
    upper_o = ~upper_o;
    last_r  = cyc_r;
  endtask : glitch
endmodule : switch_ctrl_model
